//--- rtl/cpsi_pkg.sv
// Purpose: Shared constants for the core control-state block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Register byte offsets are the printed offsets
package cpsi_pkg;
  localparam int PC_W        = 13;
  localparam int STK_DEPTH   = 8;
  localparam int STK_PTR_W   = 3;
  localparam int ADDR_W      = 9;
  localparam int PT_W        = 8;

  localparam logic [8:0] OFF_INDIRECT   = 9'h000;
  localparam logic [8:0] OFF_PC_LOW     = 9'h002;
  localparam logic [8:0] OFF_STATUS     = 9'h003;
  localparam logic [8:0] OFF_POINTER    = 9'h004;
  localparam logic [8:0] OFF_PC_LATCH   = 9'h00a;
  localparam logic [8:0] OFF_RESET_CAUSE = 9'h08e;
  localparam logic [8:0] OFF_OSC_TRIM   = 9'h090;

  localparam int BIT_POR       = 1;
  localparam int BIT_BROWNOUT  = 0;
  localparam int BIT_BANK_TOP  = 7;
  localparam int TRIM_LSB      = 2;

  localparam logic [5:0] TRIM_CENTRE = 6'h20;
  localparam logic [7:0] TRIM_RESET  = 8'h80;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [12:0] PC_RESET   = 13'h0000;

  typedef enum logic [2:0] {
    CPSI_OP_NONE,
    CPSI_OP_STEP,
    CPSI_OP_CALL,
    CPSI_OP_JUMP,
    CPSI_OP_RETURN,
    CPSI_OP_VECTOR
  } cpsi_op_t;
endpackage

//--- rtl/cpsi_stack_if.sv
// Purpose: Push/pop carrier between core and return stack
// Assumes: Single clock
// Notes:   Push and pop never both high
interface cpsi_stack_if;
  logic        push;
  logic        pop;
  logic [12:0] push_data;
  logic [12:0] top_data;
  modport core (output push, output pop, output push_data, input top_data);
  modport stack (input push, input pop, input push_data, output top_data);
endinterface

//--- rtl/cpsi_ret_stack.sv
// Purpose: Eight-entry circular return stack
// Assumes: Push and pop exclusive
// Notes:   No overflow or underflow indication exists
module cpsi_ret_stack #(
  parameter int DEPTH = cpsi_pkg::STK_DEPTH
) (
  input  wire logic    clk_sys,
  input  wire logic    sys_rst,
  cpsi_stack_if.stack  stk
);
  logic [cpsi_pkg::PC_W-1:0]      entry [DEPTH];
  logic [cpsi_pkg::STK_PTR_W-1:0] wr_ptr;
  logic [cpsi_pkg::STK_PTR_W-1:0] top_ptr;

  assign top_ptr = wr_ptr - 3'h1;
  assign stk.top_data = entry[top_ptr];

  // Pointer wraps freely, older entries overwritten
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wr_ptr <= 3'h0;
    else if (stk.push)
      wr_ptr <= wr_ptr + 3'h1;
    else if (stk.pop)
      wr_ptr <= wr_ptr - 3'h1;
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
          entry[g] <= cpsi_pkg::PC_RESET;
        else if (stk.push && int'(wr_ptr) == g)
          entry[g] <= stk.push_data;
      end
    end
  endgenerate

  a_stack_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    stk.push && !stk.pop |=> wr_ptr == $past(wr_ptr) + 3'h1)
    else $error("stack pointer did not advance");

  a_stack_pop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    stk.pop && !stk.push |=> wr_ptr == $past(wr_ptr) - 3'h1)
    else $error("stack pointer did not retreat");
endmodule

//--- rtl/cpsi_core.sv
// Purpose: Program counter, return stack, indirect access, reset cause, trim
// Assumes: Decoder gives one op per cycle; data memory external
// Notes:   Register read data appear the cycle after the read strobe
//
// Implementation choice: strobed register access.
module cpsi_core #(
  parameter logic [12:0] VECTOR_ADDR = 13'h0004
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        por_event,
  input  wire logic        brownout_event,
  input  wire cpsi_pkg::cpsi_op_t op,
  input  wire logic [10:0] op_target,
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [12:0] pc,
  output logic      [8:0]  mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_wr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output logic      [5:0]  trim_code
);
  cpsi_stack_if stk ();

  logic [12:0] next_pc;
  logic [7:0]  pc_high_latch;
  logic [7:0]  pointer_register;
  logic [7:0]  status_reg;
  logic        por_flag;
  logic        brownout_flag;
  logic [7:0]  osc_trim;
  logic [8:0]  eff_addr;
  logic        ind_self;
  logic [7:0]  local_rdata;
  logic        wr_pcl;

  // Stack storage is one module; pointer has no register address
  cpsi_ret_stack #(.DEPTH(cpsi_pkg::STK_DEPTH)) u_stack (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .stk     (stk)
  );

  assign wr_pcl = reg_wr && reg_addr == cpsi_pkg::OFF_PC_LOW;
  assign eff_addr = {status_reg[cpsi_pkg::BIT_BANK_TOP], pointer_register};
  assign ind_self = eff_addr == cpsi_pkg::OFF_INDIRECT;

  // Return address is the instruction after the current one
  // A same-cycle low byte write cancels the op, stack included
  assign stk.push = !wr_pcl && (op == cpsi_pkg::CPSI_OP_CALL || op == cpsi_pkg::CPSI_OP_VECTOR);
  assign stk.pop = !wr_pcl && op == cpsi_pkg::CPSI_OP_RETURN;
  assign stk.push_data = pc + 13'h0001;

  always_comb
  begin
    next_pc = pc + 13'h0001;
    case (op)
      cpsi_pkg::CPSI_OP_NONE:
        next_pc = pc;
      cpsi_pkg::CPSI_OP_CALL,
      cpsi_pkg::CPSI_OP_JUMP:
        next_pc = {pc_high_latch[4:3], op_target};
      cpsi_pkg::CPSI_OP_RETURN:
        next_pc = stk.top_data;
      cpsi_pkg::CPSI_OP_VECTOR:
        next_pc = VECTOR_ADDR;
      default:
        next_pc = pc + 13'h0001;
    endcase
    // Software write wins; its upper bits come from latch bits 4:0, not the adder
    if (wr_pcl)
      next_pc = {pc_high_latch[4:0], reg_wdata};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pc <= cpsi_pkg::PC_RESET;
    else
      pc <= next_pc;
  end

  // Latch changes only by software write, never by stack activity
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pc_high_latch <= cpsi_pkg::BYTE_ZERO;
    else if (reg_wr && reg_addr == cpsi_pkg::OFF_PC_LATCH)
      pc_high_latch <= {3'h0, reg_wdata[4:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pointer_register <= cpsi_pkg::BYTE_ZERO;
      status_reg <= cpsi_pkg::STATUS_RESET;
    end
    else
    begin
      if (reg_wr && reg_addr == cpsi_pkg::OFF_POINTER)
        pointer_register <= reg_wdata;
      if (reg_wr && reg_addr == cpsi_pkg::OFF_STATUS)
        status_reg <= reg_wdata;
    end
  end

  // Event clear wins over a same-cycle software write
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      por_flag <= 1'b1;
      brownout_flag <= 1'b1;
    end
    else
    begin
      if (por_event)
        por_flag <= 1'b0;
      else if (reg_wr && reg_addr == cpsi_pkg::OFF_RESET_CAUSE)
        por_flag <= reg_wdata[cpsi_pkg::BIT_POR];
      if (brownout_event)
        brownout_flag <= 1'b0;
      else if (reg_wr && reg_addr == cpsi_pkg::OFF_RESET_CAUSE)
        brownout_flag <= reg_wdata[cpsi_pkg::BIT_BROWNOUT];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      osc_trim <= cpsi_pkg::TRIM_RESET;
    else if (reg_wr && reg_addr == cpsi_pkg::OFF_OSC_TRIM)
      osc_trim <= {reg_wdata[7:2], 2'h0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      trim_code <= cpsi_pkg::TRIM_CENTRE;
    else
      trim_code <= osc_trim[7:cpsi_pkg::TRIM_LSB];
  end

  // Indirect port: forwarded to data memory, never stored here
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mem_addr <= 9'h000;
      mem_wdata <= cpsi_pkg::BYTE_ZERO;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
    end
    else
    begin
      // Follow pointer writes at once so the address never lags the registers
      mem_addr <= eff_addr;
      if (reg_wr && reg_addr == cpsi_pkg::OFF_POINTER)
        mem_addr[cpsi_pkg::PT_W-1:0] <= reg_wdata;
      if (reg_wr && reg_addr == cpsi_pkg::OFF_STATUS)
        mem_addr[cpsi_pkg::PT_W] <= reg_wdata[cpsi_pkg::BIT_BANK_TOP];
      mem_wdata <= reg_wdata;
      mem_wr <= reg_wr && reg_addr == cpsi_pkg::OFF_INDIRECT && !ind_self;
      mem_rd <= reg_rd && reg_addr == cpsi_pkg::OFF_INDIRECT && !ind_self;
    end
  end

  always_comb
  begin
    local_rdata = cpsi_pkg::BYTE_ZERO;
    case (reg_addr)
      cpsi_pkg::OFF_PC_LOW:      local_rdata = pc[7:0];
      cpsi_pkg::OFF_PC_LATCH:    local_rdata = pc_high_latch;
      cpsi_pkg::OFF_POINTER:     local_rdata = pointer_register;
      cpsi_pkg::OFF_STATUS:      local_rdata = status_reg;
      cpsi_pkg::OFF_RESET_CAUSE: local_rdata = {6'h00, por_flag, brownout_flag};
      cpsi_pkg::OFF_OSC_TRIM:    local_rdata = osc_trim;
      default:                   local_rdata = cpsi_pkg::BYTE_ZERO;
    endcase
  end

  // Indirect read takes the memory word standing in the strobe cycle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= cpsi_pkg::BYTE_ZERO;
    else if (reg_rd && reg_addr == cpsi_pkg::OFF_INDIRECT)
      reg_rdata <= ind_self ? cpsi_pkg::BYTE_ZERO : mem_rdata;
    else if (reg_rd)
      reg_rdata <= local_rdata;
    else
      reg_rdata <= cpsi_pkg::BYTE_ZERO;
  end

  sequence s_pcl_write;
    reg_wr && reg_addr == cpsi_pkg::OFF_PC_LOW;
  endsequence

  a_pcl_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_pcl_write |=> pc == {$past(pc_high_latch[4:0]), $past(reg_wdata)})
    else $error("pc not loaded from latch on low byte write");

  a_jump_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == cpsi_pkg::CPSI_OP_JUMP && !wr_pcl) |=> pc == {$past(pc_high_latch[4:3]), $past(op_target)})
    else $error("jump target wrong");

  a_pc_reset: assert property (@(posedge clk_sys)
    sys_rst |=> pc == cpsi_pkg::PC_RESET)
    else $error("pc not cleared by reset");

  sequence s_call;
    op == cpsi_pkg::CPSI_OP_CALL && !wr_pcl;
  endsequence
  sequence s_ret;
    op == cpsi_pkg::CPSI_OP_RETURN && !wr_pcl;
  endsequence

  sequence s_hold;
    op == cpsi_pkg::CPSI_OP_NONE && !reg_wr;
  endsequence
  sequence s_vector;
    op == cpsi_pkg::CPSI_OP_VECTOR && !wr_pcl;
  endsequence

  a_call_return: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_call ##1 s_hold ##1 s_ret |=> pc == $past(pc, 3) + 13'h0001)
    else $error("return did not restore call address");

  a_latch_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (stk.push || stk.pop) && !reg_wr |=> $stable(pc_high_latch))
    else $error("latch changed by stack");

  a_por_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    por_event |=> !por_flag)
    else $error("power-on flag not cleared");

  a_bod_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    brownout_event |=> !brownout_flag)
    else $error("brown-out flag not cleared");

  a_trim_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == cpsi_pkg::OFF_OSC_TRIM |=> reg_rdata[1:0] == 2'h0)
    else $error("trim low bits nonzero");

  a_ind_self: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_addr == cpsi_pkg::OFF_INDIRECT && ind_self && (reg_rd || reg_wr)
      |=> !mem_wr && !mem_rd && reg_rdata == cpsi_pkg::BYTE_ZERO)
    else $error("self indirect access not suppressed");

  a_cause_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == cpsi_pkg::OFF_RESET_CAUSE |=> reg_rdata[7:2] == 6'h00)
    else $error("reset cause upper bits nonzero");

  a_eff_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |-> mem_addr == {status_reg[cpsi_pkg::BIT_BANK_TOP], pointer_register})
    else $error("effective address wrong");

  a_step_inc: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op == cpsi_pkg::CPSI_OP_STEP && !wr_pcl |=> pc == $past(pc) + 13'h0001)
    else $error("pc did not step");

  a_pc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_hold |=> $stable(pc))
    else $error("pc moved without an op");

  a_call_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_call |=> pc == {$past(pc_high_latch[4:3]), $past(op_target)})
    else $error("call target wrong");

  a_vector_go: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_vector |=> pc == VECTOR_ADDR)
    else $error("vector address wrong");

  a_vector_ret: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_vector ##1 s_hold ##1 s_ret |=> pc == $past(pc, 3) + 13'h0001)
    else $error("return did not restore interrupted address");

  a_pop_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ret |=> pc == $past(stk.top_data))
    else $error("return did not load stack top");

  // Trim code trails the register by one cycle
  a_trim_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr && reg_addr == cpsi_pkg::OFF_OSC_TRIM
      |-> ##2 trim_code == $past(reg_wdata[7:cpsi_pkg::TRIM_LSB], 2))
    else $error("trim code not taken from register");

  a_ind_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr && reg_addr == cpsi_pkg::OFF_INDIRECT && !ind_self
      |=> mem_wr && mem_addr == $past(eff_addr) && mem_wdata == $past(reg_wdata))
    else $error("indirect write not forwarded");

  a_ind_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == cpsi_pkg::OFF_INDIRECT && !ind_self
      |=> mem_rd && reg_rdata == $past(mem_rdata))
    else $error("indirect read not forwarded");

  a_mem_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(reg_wr && reg_addr == cpsi_pkg::OFF_INDIRECT) |=> !mem_wr)
    else $error("memory written without indirect access");

  a_por_rearm: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr && reg_addr == cpsi_pkg::OFF_RESET_CAUSE && !por_event
      |=> por_flag == $past(reg_wdata[cpsi_pkg::BIT_POR]))
    else $error("power-on flag not rearmed");

  a_bod_rearm: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr && reg_addr == cpsi_pkg::OFF_RESET_CAUSE && !brownout_event
      |=> brownout_flag == $past(reg_wdata[cpsi_pkg::BIT_BROWNOUT]))
    else $error("brown-out flag not rearmed");
endmodule

//--- tb/cpsi_mem_model.sv
// Purpose: Data memory behind the indirect port
// Assumes: One access per pulse
// Notes:   Read is combinational; the core registers it in the strobe cycle
module cpsi_mem_model (
  input  wire logic       clk_sys,
  input  wire logic [8:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  input  wire logic       mem_wr,
  input  wire logic       mem_rd,
  output logic      [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ram [0:511];
  assign mem_rdata = ram[mem_addr];
  always @(posedge clk_sys)
  begin
    if (mem_wr)
      ram[mem_addr] <= mem_wdata;
  end
endmodule

//--- tb/core_pc_stack_indirect_tb_top.sv
// Purpose: Register, program counter, stack and indirect checks
// Assumes: Read data one cycle after the read strobe
// Notes:   Stack expectation kept in a local circular model
module core_pc_stack_indirect_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic               por_event = 1'b0;
  logic               brownout_event = 1'b0;
  cpsi_pkg::cpsi_op_t op = cpsi_pkg::CPSI_OP_NONE;
  logic [10:0]        op_target = 11'h000;
  logic [8:0]         reg_addr = 9'h000;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata;
  logic [7:0]         mem_wdata;
  logic [7:0]         mem_rdata;
  logic [12:0]        pc;
  logic [8:0]         mem_addr;
  logic               mem_wr;
  logic               mem_rd;
  logic [5:0]         trim_code;
  logic [12:0]        stk [0:7];
  logic [2:0]         sp = 3'h0;
  logic [12:0]        pc_exp = 13'h0000;
  int                 errors = 0;
  int                 tests_run = 0;
  int                 cycles = 0;

  cpsi_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .por_event(por_event),
    .brownout_event(brownout_event), .op(op), .op_target(op_target), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .trim_code(trim_code));
  cpsi_mem_model mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  always #20 clk_sys = ~clk_sys;
  // Whole run is under two hundred cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input string what, input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, {5'h00, exp}, {5'h00, reg_rdata});
  endtask

  task automatic exec(input cpsi_pkg::cpsi_op_t o, input logic [10:0] t, input logic [12:0] exp);
    if (o == cpsi_pkg::CPSI_OP_RETURN)
    begin
      sp = sp - 3'h1;
      exp = stk[sp];
    end
    else if (o == cpsi_pkg::CPSI_OP_CALL || o == cpsi_pkg::CPSI_OP_VECTOR)
    begin
      stk[sp] = pc_exp + 13'h0001;
      sp = sp + 3'h1;
    end
    @(posedge clk_sys);
    op <= o;
    op_target <= t;
    @(posedge clk_sys);
    op <= cpsi_pkg::CPSI_OP_NONE;
    #1;
    pc_exp = exp;
    chk("pc", exp, pc);
  endtask

  task automatic pulse(input logic bo);
    @(posedge clk_sys);
    por_event <= ~bo;
    brownout_event <= bo;
    @(posedge clk_sys);
    por_event <= 1'b0;
    brownout_event <= 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk("pc", 13'h0000, pc);
    rdc("reset_cause", cpsi_pkg::OFF_RESET_CAUSE, 8'h03);
    rdc("osc_trim", cpsi_pkg::OFF_OSC_TRIM, 8'h80);
    chk("trim_code", 13'h0020, {7'h00, trim_code});
    pulse(1'b0);
    rdc("reset_cause", cpsi_pkg::OFF_RESET_CAUSE, 8'h01);
    pulse(1'b1);
    rdc("reset_cause", cpsi_pkg::OFF_RESET_CAUSE, 8'h00);
    wr(cpsi_pkg::OFF_RESET_CAUSE, 8'hff);
    rdc("reset_cause", cpsi_pkg::OFF_RESET_CAUSE, 8'h03);
    wr(cpsi_pkg::OFF_OSC_TRIM, 8'hff);
    rdc("osc_trim", cpsi_pkg::OFF_OSC_TRIM, 8'hfc);
    chk("trim_code", 13'h003f, {7'h00, trim_code});
    wr(cpsi_pkg::OFF_OSC_TRIM, 8'h03);
    rdc("osc_trim", cpsi_pkg::OFF_OSC_TRIM, 8'h00);
    chk("trim_code", 13'h0000, {7'h00, trim_code});
    wr(cpsi_pkg::OFF_PC_LATCH, 8'hff);
    wr(cpsi_pkg::OFF_PC_LOW, 8'h34);
    pc_exp = 13'h1f34;
    chk("pc", 13'h1f34, pc);
    rdc("pc_low_byte", cpsi_pkg::OFF_PC_LOW, 8'h34);
    wr(cpsi_pkg::OFF_PC_LATCH, 8'h18);
    exec(cpsi_pkg::CPSI_OP_CALL, 11'h123, 13'h1923);
    exec(cpsi_pkg::CPSI_OP_RETURN, 11'h000, 13'h0000);
    rdc("pc_high_latch", cpsi_pkg::OFF_PC_LATCH, 8'h18);
    exec(cpsi_pkg::CPSI_OP_JUMP, 11'h7ff, 13'h1fff);
    wr(cpsi_pkg::OFF_PC_LATCH, 8'h00);
    for (int i = 1; i <= 9; i++)
      exec(cpsi_pkg::CPSI_OP_CALL, 11'(i * 16), 13'(i * 16));
    for (int i = 1; i <= 9; i++)
      exec(cpsi_pkg::CPSI_OP_RETURN, 11'h000, 13'h0000);
    exec(cpsi_pkg::CPSI_OP_VECTOR, 11'h000, 13'h0004);
    exec(cpsi_pkg::CPSI_OP_RETURN, 11'h000, 13'h0000);
    exec(cpsi_pkg::CPSI_OP_STEP, 11'h000, pc_exp + 13'h0001);
    wr(cpsi_pkg::OFF_STATUS, 8'h80);
    wr(cpsi_pkg::OFF_POINTER, 8'h25);
    wr(cpsi_pkg::OFF_INDIRECT, 8'h5a);
    chk("mem_wr", 13'h0001, {12'h000, mem_wr});
    chk("mem_wdata", 13'h005a, {5'h00, mem_wdata});
    chk("mem_addr", 13'h0125, {4'h0, mem_addr});
    rdc("indirect_port", cpsi_pkg::OFF_INDIRECT, 8'h5a);
    chk("mem_rd", 13'h0001, {12'h000, mem_rd});
    wr(cpsi_pkg::OFF_STATUS, 8'h00);
    wr(cpsi_pkg::OFF_POINTER, 8'h00);
    wr(cpsi_pkg::OFF_INDIRECT, 8'h77);
    chk("mem_wr", 13'h0000, {12'h000, mem_wr});
    rdc("indirect_port", cpsi_pkg::OFF_INDIRECT, 8'h00);
    chk("mem_rd", 13'h0000, {12'h000, mem_rd});
    rdc("unmapped", 9'h1ff, 8'h00);
    wr(cpsi_pkg::OFF_PC_LATCH, 8'h01);
    wr(cpsi_pkg::OFF_PC_LOW, 8'hff);
    pc_exp = 13'h01ff;
    chk("pc", 13'h01ff, pc);
    exec(cpsi_pkg::CPSI_OP_STEP, 11'h000, 13'h0200);
    wr(cpsi_pkg::OFF_PC_LOW, 8'h05);
    chk("pc", 13'h0105, pc);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    sp = 3'h0;
    pc_exp = 13'h0000;
    chk("pc", 13'h0000, pc);
    rdc("reset_cause", cpsi_pkg::OFF_RESET_CAUSE, 8'h03);
    rdc("osc_trim", cpsi_pkg::OFF_OSC_TRIM, 8'h80);
    end_of_test();
  end
endmodule
